// ### psa_pkg.sv
// Constants and types shared by the packed-integer SIMD ALU.
package psa_pkg;

  // Saturation ceiling of an unsigned word, used by the range clip.
  localparam logic [15:0] SAT_TOP = 16'hffff;

  // Cycles from a taken request to its result.
  localparam int unsigned LATENCY = 1;

  // Lane geometry.
  localparam int unsigned WORD_LANES  = 8;
  localparam int unsigned DWORD_LANES = 4;
  localparam int unsigned HALF_W      = 64;

  // Operation select.
  typedef enum logic [3:0] {
    OP_CLIP      = 4'h0,
    OP_MAX       = 4'h1,
    OP_MIN       = 4'h2,
    OP_MUL_HIGH  = 4'h3,
    OP_MUL_LOW_W = 4'h4,
    OP_MUL_WIDE_U = 4'h5,
    OP_MUL_WIDE_S = 4'h6,
    OP_MUL_LOW_D = 4'h7,
    OP_SAD       = 4'h8,
    OP_MULTI_SAD = 4'h9,
    OP_AVERAGE   = 4'ha,
    OP_MADD      = 4'hb
  } psa_op_type;

  // Lane size select.
  typedef enum logic [1:0] {
    LANE_BYTE  = 2'h0,
    LANE_WORD  = 2'h1,
    LANE_DWORD = 2'h2
  } psa_lane_type;

endpackage

// ### psa_word_lane.sv
// One 16-bit lane: clip, byte/word max and min, average and multiply.
`timescale 1ns/1ps
`default_nettype none
module psa_word_lane (
  // Lane operands.
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  // Lane mode.
  input  wire logic        signed_i,
  input  wire logic        byte_mode_i,
  // Clip bounds.
  input  wire logic [15:0] high_i,
  input  wire logic [15:0] low_i,
  // Lane results.
  output logic      [15:0] clip_o,
  output logic      [15:0] max_o,
  output logic      [15:0] min_o,
  output logic      [15:0] avg_o,
  output logic      [31:0] prod_o
);

  logic        [16:0] up_sum;
  logic        [15:0] up_sat;
  logic        [15:0] down_off;
  logic        [16:0] down_diff;
  logic        [15:0] down_sat;
  logic               lt_w;
  logic               lt_b0;
  logic               lt_b1;
  logic        [16:0] avg_w;
  logic        [8:0]  avg_b0;
  logic        [8:0]  avg_b1;
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] prod_full;

  // Clip in three steps; the offsets and the last add wrap freely, the first add and the subtract saturate.
  assign up_sum    = {1'b0, a_i} + {1'b0, psa_pkg::SAT_TOP - high_i};
  assign up_sat    = up_sum[16] ? psa_pkg::SAT_TOP : up_sum[15:0];
  assign down_off  = psa_pkg::SAT_TOP - high_i + low_i;
  assign down_diff = {1'b0, up_sat} - {1'b0, down_off};
  assign down_sat  = down_diff[16] ? 16'h0000 : down_diff[15:0];
  assign clip_o    = down_sat + low_i;

  // Less-than per lane size, signed or unsigned.
  assign lt_w  = signed_i ? ($signed(a_i) < $signed(b_i)) : (a_i < b_i);
  assign lt_b0 = signed_i ? ($signed(a_i[7:0]) < $signed(b_i[7:0]))
                          : (a_i[7:0] < b_i[7:0]);
  assign lt_b1 = signed_i ? ($signed(a_i[15:8]) < $signed(b_i[15:8]))
                          : (a_i[15:8] < b_i[15:8]);

  // Max and min pick whole byte or word lanes of an operand, so no arithmetic width hazard.
  assign max_o = byte_mode_i ? {lt_b1 ? b_i[15:8] : a_i[15:8],
                                lt_b0 ? b_i[7:0] : a_i[7:0]}
                             : (lt_w ? b_i : a_i);
  assign min_o = byte_mode_i ? {lt_b1 ? a_i[15:8] : b_i[15:8],
                                lt_b0 ? a_i[7:0] : b_i[7:0]}
                             : (lt_w ? a_i : b_i);

  // Rounding average; the carry-out becomes the top bit of the lane.
  assign avg_w  = {1'b0, a_i} + {1'b0, b_i} + 17'h00001;
  assign avg_b0 = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]} + 9'h001;
  assign avg_b1 = {1'b0, a_i[15:8]} + {1'b0, b_i[15:8]} + 9'h001;
  assign avg_o  = byte_mode_i ? {avg_b1[8:1], avg_b0[8:1]}
                              : avg_w[16:1];

  // One 17x17 signed multiplier serves both signed and unsigned words.
  assign a_ext     = $signed({signed_i & a_i[15], a_i});
  assign b_ext     = $signed({signed_i & b_i[15], b_i});
  assign prod_full = a_ext * b_ext;
  assign prod_o    = prod_full[31:0];

endmodule
`default_nettype wire

// ### psa_simd_alu.sv
// Packed-integer SIMD ALU with a one-stage result register.
`timescale 1ns/1ps
`default_nettype none
module psa_simd_alu (
  // Clock and reset.
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // Request from the issue stage.
  input  wire logic                  valid_i,
  input  wire psa_pkg::psa_op_type   op_i,
  input  wire psa_pkg::psa_lane_type lane_i,
  input  wire logic                  signed_i,
  input  wire logic                  wide_i,
  input  wire logic [127:0]          a_i,
  input  wire logic [127:0]          b_i,
  // Clip bounds.
  input  wire logic [15:0]           clip_high_i,
  input  wire logic [15:0]           clip_low_i,
  // Result to the register file.
  output logic                       valid_o,
  output logic      [127:0]          result_o
);

  // **************************************************
  // Word lanes
  // **************************************************

  logic [15:0] clip_w [psa_pkg::WORD_LANES];
  logic [15:0] max_w  [psa_pkg::WORD_LANES];
  logic [15:0] min_w  [psa_pkg::WORD_LANES];
  logic [15:0] avg_w  [psa_pkg::WORD_LANES];
  logic [31:0] prod_w [psa_pkg::WORD_LANES];
  logic        lane_signed;
  logic        byte_mode;

  // Low-word and multiply-add products are always signed.
  assign lane_signed = signed_i || (op_i == psa_pkg::OP_MUL_LOW_W)
                       || (op_i == psa_pkg::OP_MADD);
  assign byte_mode   = (lane_i == psa_pkg::LANE_BYTE);

  for (genvar w = 0; w < psa_pkg::WORD_LANES; w++) begin : g_word
    psa_word_lane u_lane (
      .a_i         (a_i[16*w +: 16]),
      .b_i         (b_i[16*w +: 16]),
      .signed_i    (lane_signed),
      .byte_mode_i (byte_mode),
      .high_i      (clip_high_i),
      .low_i       (clip_low_i),
      .clip_o      (clip_w[w]),
      .max_o       (max_w[w]),
      .min_o       (min_w[w]),
      .avg_o       (avg_w[w]),
      .prod_o      (prod_w[w])
    );
  end

  // **************************************************
  // Dword lanes
  // **************************************************

  logic [31:0] max_d [psa_pkg::DWORD_LANES];
  logic [31:0] min_d [psa_pkg::DWORD_LANES];
  logic [31:0] lo_d  [psa_pkg::DWORD_LANES];
  logic [63:0] wide_d [2];

  for (genvar d = 0; d < psa_pkg::DWORD_LANES; d++) begin : g_dword
    logic [31:0] da;
    logic [31:0] db;
    logic        lt;
    assign da = a_i[32*d +: 32];
    assign db = b_i[32*d +: 32];
    assign lt = signed_i ? ($signed(da) < $signed(db)) : (da < db);
    assign max_d[d] = lt ? db : da;
    assign min_d[d] = lt ? da : db;
    // Low half of a product is the same for signed and unsigned inputs.
    assign lo_d[d]  = da * db;
  end

  // Each 64-bit chunk multiplies its low dwords on its own.
  for (genvar c = 0; c < 2; c++) begin : g_chunk
    logic [31:0]        ca;
    logic [31:0]        cb;
    logic signed [65:0] full;
    logic               sx;
    assign ca = a_i[64*c +: 32];
    assign cb = b_i[64*c +: 32];
    assign sx = (op_i == psa_pkg::OP_MUL_WIDE_S);
    assign full = $signed({sx & ca[31], ca}) * $signed({sx & cb[31], cb});
    assign wide_d[c] = full[63:0];
  end

  // **************************************************
  // Sums of absolute differences
  // **************************************************

  function automatic logic [7:0] abs_diff(input logic [7:0] x,
                                          input logic [7:0] y);
    abs_diff = (x > y) ? (x - y) : (y - x);
  endfunction

  logic [15:0] sad_h [2];
  logic [15:0] msad  [psa_pkg::WORD_LANES];

  // Eight byte pairs per half, summed into one word.
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      sad_h[h] = 16'h0000;
      for (int k = 0; k < 8; k++) begin
        sad_h[h] = sad_h[h] + {8'h00, abs_diff(a_i[64*h + 8*k +: 8],
                                              b_i[64*h + 8*k +: 8])};
      end
    end
  end

  // Block k compares bytes k..k+3 of a with bytes 0..3 of b.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      msad[k] = 16'h0000;
      for (int j = 0; j < 4; j++) begin
        msad[k] = msad[k] + {8'h00, abs_diff(a_i[8*(k+j) +: 8],
                                            b_i[8*j +: 8])};
      end
    end
  end

  // **************************************************
  // Result select
  // **************************************************

  logic [127:0] next_result;

  // Narrow requests clear the upper half, matching a 64-bit register.
  always_comb begin
    next_result = '0;
    case (op_i)
      psa_pkg::OP_CLIP: begin
        for (int w = 0; w < 8; w++) next_result[16*w +: 16] = clip_w[w];
      end
      psa_pkg::OP_MAX: begin
        for (int w = 0; w < 8; w++) next_result[16*w +: 16] = max_w[w];
        if (lane_i == psa_pkg::LANE_DWORD) begin
          for (int d = 0; d < 4; d++) next_result[32*d +: 32] = max_d[d];
        end
      end
      psa_pkg::OP_MIN: begin
        for (int w = 0; w < 8; w++) next_result[16*w +: 16] = min_w[w];
        if (lane_i == psa_pkg::LANE_DWORD) begin
          for (int d = 0; d < 4; d++) next_result[32*d +: 32] = min_d[d];
        end
      end
      psa_pkg::OP_MUL_HIGH: begin
        for (int w = 0; w < 8; w++) begin
          next_result[16*w +: 16] = prod_w[w][31:16];
        end
      end
      psa_pkg::OP_MUL_LOW_W: begin
        for (int w = 0; w < 8; w++) begin
          next_result[16*w +: 16] = prod_w[w][15:0];
        end
      end
      psa_pkg::OP_MUL_WIDE_U,
      psa_pkg::OP_MUL_WIDE_S: begin
        next_result = {wide_d[1], wide_d[0]};
      end
      psa_pkg::OP_MUL_LOW_D: begin
        for (int d = 0; d < 4; d++) next_result[32*d +: 32] = lo_d[d];
      end
      psa_pkg::OP_SAD: begin
        next_result[15:0]  = sad_h[0];
        next_result[79:64] = sad_h[1];
      end
      psa_pkg::OP_MULTI_SAD: begin
        for (int k = 0; k < 8; k++) next_result[16*k +: 16] = msad[k];
      end
      psa_pkg::OP_AVERAGE: begin
        for (int w = 0; w < 8; w++) next_result[16*w +: 16] = avg_w[w];
      end
      psa_pkg::OP_MADD: begin
        for (int p = 0; p < 4; p++) begin
          next_result[32*p +: 32] = prod_w[2*p] + prod_w[2*p+1];
        end
      end
      default: begin
        next_result = '0;
      end
    endcase
    if (!wide_i) begin
      next_result[127:64] = 64'h0000_0000_0000_0000;
    end
  end

  // **************************************************
  // Output stage
  // **************************************************

  // Valid follows the request by exactly one edge.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
    end
  end

  // The result holds between requests so the register file sees it stable.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (valid_i) begin
      result_o <= next_result;
    end
  end

  // **************************************************
  // Checks
  // **************************************************

  default clocking cb_main @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_take(psa_pkg::psa_op_type o);
    valid_i && op_i == o;
  endsequence

  chk_valid_latency: assert property (
    valid_i |=> valid_o)
    else $error("Result valid missing one cycle after request.");

  chk_no_spurious: assert property (
    !valid_i |=> !valid_o && $stable(result_o))
    else $error("Result changed or valid without a request.");

  chk_max_sword: assert property (
    s_take(psa_pkg::OP_MAX) ##0 (lane_i == psa_pkg::LANE_WORD && signed_i)
    |=> $signed(result_o[15:0]) >= $signed($past(a_i[15:0]))
     && $signed(result_o[15:0]) >= $signed($past(b_i[15:0])))
    else $error("Signed word max not the larger lane.");

  chk_min_ubyte: assert property (
    s_take(psa_pkg::OP_MIN) ##0 (lane_i == psa_pkg::LANE_BYTE && !signed_i)
    |=> result_o[15:8] <= $past(a_i[15:8])
     && result_o[15:8] <= $past(b_i[15:8]))
    else $error("Unsigned byte min not the smaller lane.");

  chk_mul_high: assert property (
    s_take(psa_pkg::OP_MUL_HIGH) ##0 !signed_i
    |=> result_o[31:16] == 16'(({16'h0000, $past(a_i[31:16])}
                                * {16'h0000, $past(b_i[31:16])}) >> 16))
    else $error("Unsigned high word multiply wrong.");

  chk_wide_unsigned: assert property (
    s_take(psa_pkg::OP_MUL_WIDE_U) ##0 wide_i
    |=> result_o[127:64] == {32'h0, $past(a_i[95:64])}
                            * {32'h0, $past(b_i[95:64])})
    else $error("Upper chunk wide multiply wrong.");

  chk_sad_zero_top: assert property (
    s_take(psa_pkg::OP_SAD)
    |=> result_o[63:16] == 48'h0 && result_o[127:80] == 48'h0)
    else $error("SAD upper words not cleared.");

  chk_avg_word: assert property (
    s_take(psa_pkg::OP_AVERAGE) ##0 lane_i == psa_pkg::LANE_WORD
    |=> result_o[15:0] == 16'(({1'b0, $past(a_i[15:0])}
                               + {1'b0, $past(b_i[15:0])} + 17'h1) >> 1))
    else $error("Word average wrong.");

  chk_clip_range: assert property (
    s_take(psa_pkg::OP_CLIP) ##0 clip_low_i <= clip_high_i
    |=> result_o[15:0] >= $past(clip_low_i)
     && result_o[15:0] <= $past(clip_high_i))
    else $error("Clip result outside bounds.");

  chk_narrow_top: assert property (
    valid_i && !wide_i |=> result_o[127:64] == 64'h0)
    else $error("Narrow result has upper half set.");

endmodule
`default_nettype wire

// ### psa_issue_model.sv
// Issue-stage model that presents requests to the SIMD ALU.
`timescale 1ns/1ps
`default_nettype none
module psa_issue_model (
  // Clock.
  input  wire logic             clock_i,
  // Request towards the ALU.
  output logic                  valid_o,
  output psa_pkg::psa_op_type   op_o,
  output psa_pkg::psa_lane_type lane_o,
  output logic                  signed_o,
  output logic                  wide_o,
  output logic [127:0]          a_o,
  output logic [127:0]          b_o,
  output logic [15:0]           high_o,
  output logic [15:0]           low_o
);
  // Quiet bus at time zero so nothing is taken before the first request.
  initial begin
    valid_o  = 1'b0;
    op_o     = psa_pkg::OP_CLIP;
    lane_o   = psa_pkg::LANE_BYTE;
    signed_o = 1'b0;
    wide_o   = 1'b0;
    a_o      = '0;
    b_o      = '0;
    high_o   = 16'hffff;
    low_o    = 16'h0000;
  end

  // One request per call, all fields changed together after an edge.
  // The result always goes to a register, so a memory source is just
  // another operand value here.
  task automatic issue(input int op, input int ln, input bit sg,
                       input bit wd, input logic [127:0] a,
                       input logic [127:0] b, input logic [15:0] hi,
                       input logic [15:0] lo);
    @(posedge clock_i);
    valid_o  <= 1'b1;
    op_o     <= psa_pkg::psa_op_type'(op[3:0]);
    lane_o   <= psa_pkg::psa_lane_type'(ln[1:0]);
    signed_o <= sg;
    wide_o   <= wd;
    a_o      <= a;
    b_o      <= b;
    high_o   <= hi;
    low_o    <= lo;
  endtask

  // Idle cycle: operands are scrambled so stale values never look valid.
  task automatic idle();
    @(posedge clock_i);
    valid_o <= 1'b0;
    a_o     <= ~a_o;
    b_o     <= ~b_o;
    high_o  <= ~high_o;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the SIMD ALU against an integer model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Start values given here raise no edge, so no check runs at time zero.
  logic                  clock_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  valid_i;
  psa_pkg::psa_op_type   op_i;
  psa_pkg::psa_lane_type lane_i;
  logic                  signed_i;
  logic                  wide_i;
  logic [127:0]          a_i;
  logic [127:0]          b_i;
  logic [15:0]           clip_high_i;
  logic [15:0]           clip_low_i;
  logic                  valid_o;
  logic [127:0]          result_o;
  logic                  exp_v;
  logic [127:0]          last;
  logic [127:0]          pend[$];
  int                    fails;
  int                    n_compared;

  psa_issue_model issue_model (.clock_i(clock_i), .valid_o(valid_i),
    .op_o(op_i), .lane_o(lane_i), .signed_o(signed_i), .wide_o(wide_i),
    .a_o(a_i), .b_o(b_i), .high_o(clip_high_i), .low_o(clip_low_i));

  psa_simd_alu DUT (.clock_i(clock_i), .rst_i(rst_i), .valid_i(valid_i),
    .op_i(op_i), .lane_i(lane_i), .signed_i(signed_i), .wide_i(wide_i),
    .a_i(a_i), .b_i(b_i), .clip_high_i(clip_high_i),
    .clip_low_i(clip_low_i), .valid_o(valid_o), .result_o(result_o));

  // ****************************************
  // Reference model.
  // ****************************************

  // Lane k of width w, sign-extended when asked.
  function automatic longint el(logic [127:0] v, int w, int k, bit sg);
    longint x;
    x = longint'((v >> (w * k)) & ((128'h1 << w) - 128'h1));
    if (sg && x[w - 1])
      x = x - (longint'(1) << w);
    return x;
  endfunction

  function automatic logic [127:0] put(logic [127:0] r, int w, int k,
                                       longint v);
    return r | ((128'(v) & ((128'h1 << w) - 128'h1)) << (w * k));
  endfunction

  // Expected result; 64-bit requests see the upper half cleared.
  function automatic logic [127:0] model(int op, int ln, bit sg, bit wd,
      logic [127:0] a, logic [127:0] b, longint hi, longint lo);
    logic [127:0] r;
    longint x;
    longint y;
    longint s;
    int w;
    r = '0;
    w = (op == 10) ? ((ln == 0) ? 8 : 16) : (8 << ln);
    for (int k = 0; k < 16; k++) begin
      x = el(a, 8, k, 0) - el(b, 8, k, 0);
      s = 0;
      case (op)
        0: if (k < 8) begin
          x = el(a, 16, k, 0) + 65535 - hi;
          x = (x > 65535) ? 65535 : x;
          s = 65535 - hi + lo;
          r = put(r, 16, k, ((x > s) ? x - s : 0) + lo);
        end
        1, 2: if (k < 128 / w) begin
          x = el(a, w, k, sg);
          y = el(b, w, k, sg);
          r = put(r, w, k, ((x > y) == (op == 1)) ? x : y);
        end
        3, 4: if (k < 8) begin
          x = el(a, 16, k, sg || op == 4) * el(b, 16, k, sg || op == 4);
          r = put(r, 16, k, (op == 3) ? (x >>> 16) : x);
        end
        5, 6: if (k < 2)
          r = put(r, 64, k, el(a, 32, 2 * k, op == 6) *
                            el(b, 32, 2 * k, op == 6));
        7: if (k < 4)
          r = put(r, 32, k, el(a, 32, k, 1) * el(b, 32, k, 1));
        8: r = r + (128'((x < 0) ? -x : x) << (64 * (k / 8)));
        9: if (k < 8) begin
          for (int j = 0; j < 4; j++) begin
            x = el(a, 8, k + j, 0) - el(b, 8, j, 0);
            s = s + ((x < 0) ? -x : x);
          end
          r = put(r, 16, k, s);
        end
        10: if (k < 128 / w)
          r = put(r, w, k, (el(a, w, k, 0) + el(b, w, k, 0) + 1) >> 1);
        11: if (k < 4)
          r = put(r, 32, k, el(a, 16, 2 * k, 1) * el(b, 16, 2 * k, 1) +
                    el(a, 16, 2 * k + 1, 1) * el(b, 16, 2 * k + 1, 1));
        default: ;
      endcase
    end
    if (!wd)
      r[127:64] = '0;
    return r;
  endfunction

  // ****************************************
  // Checking.
  // ****************************************

  task automatic chk_bit(string name, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic chk_vec(string name, logic [127:0] e, logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  // Every taken request queues its expected result for the next cycle.
  always @(posedge clock_i) begin
    if (rst_i) begin
      exp_v <= 1'b0;
    end else begin
      exp_v <= valid_i;
      if (valid_i)
        pend.push_back(model(int'(op_i), int'(lane_i), signed_i, wide_i,
                             a_i, b_i, clip_high_i, clip_low_i));
    end
  end

  // Outputs are looked at mid-cycle, where they have settled.
  always @(negedge clock_i) begin
    if (rst_i) begin
      pend.delete();
      last = '0;
      chk_bit("valid_o in reset", 1'b0, valid_o);
      chk_vec("result_o in reset", '0, result_o);
    end else begin
      chk_bit("valid_o", exp_v, valid_o);
      if (exp_v && pend.size() > 0)
        last = pend.pop_front();
      chk_vec("result_o", last, result_o);
    end
  end

  // ****************************************
  // Stimulus.
  // ****************************************

  // Random operands, often replaced by lane boundary patterns.
  task automatic send(int op, int ln, bit sg, bit wd);
    logic [127:0] a;
    logic [127:0] b;
    logic [15:0]  lo;
    a = {$urandom, $urandom, $urandom, $urandom};
    b = {$urandom, $urandom, $urandom, $urandom};
    if ($urandom % 4 == 0)
      a = {8{16'h8000}};
    if ($urandom % 4 == 0)
      b = {16{8'hff}};
    lo = 16'($urandom);
    issue_model.issue(op, ln, sg, wd, a, b,
                      lo + 16'($urandom % (65536 - int'(lo))), lo);
  endtask

  task automatic print_verdict();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always #2.5 clock_i = ~clock_i;

  // Watchdog: the run needs about 270 cycles.
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    print_verdict();
  end

  // Every op code, lane size, signedness and width, mostly back to back.
  initial begin
    fails = 0;
    n_compared = 0;
    void'($urandom(32'h4eaa35fd));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    $display("test reset done");
    for (int op = 0; op < 16; op++) begin
      for (int m = 0; m < 12; m++) begin
        send(op, m / 4, m[0], m[1]);
        if ($urandom % 4 == 0)
          issue_model.idle();
      end
    end
    $display("test sweep done");
    // A reset that lands while results are still in flight.
    // The strobe drops with reset so no stale request is taken after it.
    send(11, 1, 1, 1);
    issue_model.idle();
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    send(8, 0, 0, 1);
    repeat (3) issue_model.idle();
    $display("test mid reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
